// ### hdl/tcs_map.svh
// Register offsets, field positions, reset values for the cycle status block.
// Behaviour
// - Upper status bits fifteen to eight read zero.
// - Channel six bits seven-four show count direction.
// - Channel seven direction bits always read zero.
// - Non-complementary mode: flag sets on cycle match.
// - Complementary mode: flag sets at zero counting down.
// - Flag clears by read-at-one then write-zero.
// - Writes only clear flags; direction ignores writes.
`ifndef TCS_MAP_SVH
`define TCS_MAP_SVH
`define TCS_OFF_STAT6   8'h00
`define TCS_OFF_STAT7   8'h04
`define TCS_OFF_IRQ_ST  8'h08
`define TCS_OFF_IRQ_MSK 8'h0C
`define TCS_OFF_MODE    8'h10
`define TCS_DIR_LSB     4
`define TCS_FLAG_LSB    0
`define TCS_STAT_RESET  16'h0000
`define TCS_IRQ_RESET   8'h00
`define TCS_ZERO_CNT    16'h0000
`endif

// ### hdl/tcs_pkg.sv
// Types shared by the cycle status block.
package tcs_pkg;
  // One sub-counter's view: count, period value and direction.
  typedef struct packed {
    logic [15:0] count;
    logic [15:0] period;
    logic        down;
  } tcs_sub_t;
  // Wishbone request as a bundle.
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } tcs_wb_req_t;
endpackage : tcs_pkg

// ### hdl/tcs_cycle_status.sv
// Cycle status registers for timer channels six and seven with Wishbone.
//
// Decided for this implementation: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "tcs_map.svh"
module tcs_cycle_status
  import tcs_pkg::*;
#(
  parameter int NSUB = 4
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_resetn,
  input  wire tcs_wb_req_t       i_wb,
  output logic [31:0]            o_wb_dat,
  output logic                   o_wb_ack,
  input  wire tcs_sub_t [NSUB-1:0] i_ch6,
  input  wire tcs_sub_t [NSUB-1:0] i_ch7,
  output logic                   o_irq
);

  // Flags of both channels, mode select, interrupt status and mask.
  logic [NSUB-1:0] flag6_ff;
  logic [NSUB-1:0] flag7_ff;
  logic [NSUB-1:0] armed6_ff;         // Flag seen at one by a read.
  logic [NSUB-1:0] armed7_ff;
  logic            comp_mode_ff;      // One selects complementary mode.
  logic [7:0]      irq_st_ff;
  logic [7:0]      irq_msk_ff;
  logic            ack_ff;
  logic [31:0]     rdat_ff;
  logic [NSUB-1:0] set6;
  logic [NSUB-1:0] set7;
  logic [NSUB-1:0] clr6;
  logic [NSUB-1:0] clr7;
  logic            acc;
  logic            wr;
  logic            rd;
  logic [15:0]     stat6;
  logic [15:0]     stat7;
  logic [31:0]     nxt_rdat;

  // A request is answered one cycle after it appears; ack then drops.
  assign acc = i_wb.cyc && i_wb.stb && !ack_ff;
  assign wr  = acc && i_wb.we && i_wb.sel[0];
  assign rd  = acc && !i_wb.we;

  // Set conditions per sub-counter, one generate loop.
  genvar g;
  generate
    for (g = 0; g < NSUB; g++) begin : g_set
      // Complementary mode keys both channels on the channel-six counter.
      assign set6[g] = comp_mode_ff ?
        (i_ch6[g].down && i_ch6[g].count == `TCS_ZERO_CNT) :
        (i_ch6[g].count == i_ch6[g].period);
      assign set7[g] = comp_mode_ff ?
        (i_ch6[g].down && i_ch6[g].count == `TCS_ZERO_CNT) :
        (i_ch7[g].count == i_ch7[g].period);
      // Only an armed bit written with zero clears; ones are ignored.
      assign clr6[g] = armed6_ff[g] && !i_wb.dat[g] &&
                       wr && i_wb.adr == `TCS_OFF_STAT6;
      assign clr7[g] = armed7_ff[g] && !i_wb.dat[g] &&
                       wr && i_wb.adr == `TCS_OFF_STAT7;
    end
  endgenerate

  // Status words; upper byte zero, channel seven direction zero.
  always_comb begin
    stat6 = `TCS_STAT_RESET;
    stat7 = `TCS_STAT_RESET;
    for (int i = 0; i < NSUB; i++) begin
      stat6[`TCS_DIR_LSB + i] = i_ch6[i].down;
    end
    stat6[NSUB-1:0] = flag6_ff;
    stat7[NSUB-1:0] = flag7_ff;
  end

  // Flags: set wins over clear so a match is never lost.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      flag6_ff <= '0;
      flag7_ff <= '0;
    end else begin
      flag6_ff <= set6 | (flag6_ff & ~clr6);
      flag7_ff <= set7 | (flag7_ff & ~clr7);
    end
  end

  // No channel seven flag drops unless its armed zero write clears it.
  property p_hold7;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      ((flag7_ff & ~clr7) != '0)
      |=> (flag7_ff & $past(flag7_ff & ~clr7)) == $past(flag7_ff & ~clr7);
  endproperty
  a_hold7: assert property (p_hold7)
    else $error("channel seven flag dropped without a clearing write");

  // Per sub-counter checks of the set conditions, one copy per bit.
  // The single-bit checks further down pin one index each; these watch
  // every index, so a crossed wire in the set loop is caught as well, except in channel seven's own period match.
  generate
    for (g = 0; g < NSUB; g++) begin : g_chk
      // Outside complementary mode a channel six match sets its flag.
      property p_match6;
        @(posedge i_clk_sys) disable iff (!i_resetn)
          (!comp_mode_ff && i_ch6[g].count == i_ch6[g].period)
          |=> flag6_ff[g];
      endproperty
      a_match6: assert property (p_match6)
        else $error("channel six match did not set its flag");

      // Complementary mode never sets a flag while channel six counts up.
      property p_no_up_zero;
        @(posedge i_clk_sys) disable iff (!i_resetn)
          (comp_mode_ff && !i_ch6[g].down && !flag6_ff[g])
          |=> !flag6_ff[g];
      endproperty
      a_no_up_zero: assert property (p_no_up_zero)
        else $error("flag set while counting up in complementary mode");

      // In complementary mode channel seven ignores its own period match.
      property p_comp7_key;
        @(posedge i_clk_sys) disable iff (!i_resetn)
          (comp_mode_ff && !flag7_ff[g] &&
           !(i_ch6[g].down && i_ch6[g].count == `TCS_ZERO_CNT))
          |=> !flag7_ff[g];
      endproperty
      a_comp7_key: assert property (p_comp7_key)
        else $error("channel seven flag set without the channel six key");
    end
  endgenerate

  // Arming: a read that sees a flag at one enables its later clear.
  // A bit that drops to zero disarms, so a stale read cannot clear a
  // fresh event.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      armed6_ff <= '0;
      armed7_ff <= '0;
    end else begin
      if (rd && i_wb.adr == `TCS_OFF_STAT6) begin
        armed6_ff <= flag6_ff;
      end else begin
        armed6_ff <= armed6_ff & flag6_ff & ~clr6;
      end
      if (rd && i_wb.adr == `TCS_OFF_STAT7) begin
        armed7_ff <= flag7_ff;
      end else begin
        armed7_ff <= armed7_ff & flag7_ff & ~clr7;
      end
    end
  end

  // A status read arms exactly the flags that it saw at one.
  property p_arm;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (rd && i_wb.adr == `TCS_OFF_STAT6) |=> armed6_ff == $past(flag6_ff);
  endproperty
  a_arm: assert property (p_arm)
    else $error("status read did not arm the flags it saw");

  // Mode and interrupt mask registers.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      comp_mode_ff <= 1'b0;
      irq_msk_ff   <= `TCS_IRQ_RESET;
    end else if (wr) begin
      if (i_wb.adr == `TCS_OFF_MODE) begin
        comp_mode_ff <= i_wb.dat[0];
      end
      if (i_wb.adr == `TCS_OFF_IRQ_MSK) begin
        irq_msk_ff <= i_wb.dat[7:0];
      end
    end
  end

  // A mode write with the low lane selected loads bit zero.
  property p_mode_wr;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (wr && i_wb.adr == `TCS_OFF_MODE)
      |=> comp_mode_ff == $past(i_wb.dat[0]);
  endproperty
  a_mode_wr: assert property (p_mode_wr)
    else $error("mode write not taken");

  // Without the low byte lane a write leaves mode and mask alone.
  property p_sel_gate;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (acc && i_wb.we && !i_wb.sel[0])
      |=> $stable(comp_mode_ff) && $stable(irq_msk_ff);
  endproperty
  a_sel_gate: assert property (p_sel_gate)
    else $error("write without low lane changed a register");

  // Interrupt status: low nibble channel six, high nibble seven.
  // Write one to clear; a new event in the same cycle wins.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_st_ff <= `TCS_IRQ_RESET;
    end else if (wr && i_wb.adr == `TCS_OFF_IRQ_ST) begin
      irq_st_ff <= {set7, set6} | (irq_st_ff & ~i_wb.dat[7:0]);
    end else begin
      irq_st_ff <= {set7, set6} | irq_st_ff;
    end
  end

  // The status word packs both channels as two nibbles, so it only fits
  // while NSUB keeps its default of four sub-counters.
  // Every cycle-match event lands in the sticky interrupt status.
  property p_irq_sticky;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      ({set7, set6} != '0)
      |=> (irq_st_ff & $past({set7, set6})) == $past({set7, set6});
  endproperty
  a_irq_sticky: assert property (p_irq_sticky)
    else $error("event missing from interrupt status");

  // Writing one clears a status bit when its event is quiet.
  property p_irq_w1c;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (wr && i_wb.adr == `TCS_OFF_IRQ_ST && i_wb.dat[4] && !set7[0])
      |=> !irq_st_ff[4];
  endproperty
  a_irq_w1c: assert property (p_irq_w1c)
    else $error("interrupt status bit did not clear");

  // Read mux; unmapped addresses read zero and are still acknowledged.
  always_comb begin
    nxt_rdat = 32'h0000_0000;
    unique case (i_wb.adr)
      `TCS_OFF_STAT6:   nxt_rdat = {16'h0000, stat6};
      `TCS_OFF_STAT7:   nxt_rdat = {16'h0000, stat7};
      `TCS_OFF_IRQ_ST:  nxt_rdat = {24'h000000, irq_st_ff};
      `TCS_OFF_IRQ_MSK: nxt_rdat = {24'h000000, irq_msk_ff};
      `TCS_OFF_MODE:    nxt_rdat = {31'h0, comp_mode_ff};
      default:          nxt_rdat = 32'h0000_0000;
    endcase
  end

  // Ack and read data registers.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= acc;
      if (rd) begin
        rdat_ff <= nxt_rdat;
      end
    end
  end

  assign o_wb_ack = ack_ff;
  assign o_wb_dat = rdat_ff;
  assign o_irq    = |(irq_st_ff & irq_msk_ff);

  // Flags never drop without a zero write to an armed bit.
  property p_no_spont_clr;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (flag6_ff[0] && !clr6[0]) |=> flag6_ff[0];
  endproperty
  a_no_spont_clr: assert property (p_no_spont_clr)
    else $error("flag cleared without valid write");

  // Set beats clear on every bit of both channels.
  property p_set_wins;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      ((set6 & clr6) != '0 || (set7 & clr7) != '0)
      |=> (flag6_ff & $past(set6 & clr6)) == $past(set6 & clr6)
          && (flag7_ff & $past(set7 & clr7)) == $past(set7 & clr7);
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost under clear");

  // Match in non-complementary mode sets the flag next cycle.
  property p_match_set;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (!comp_mode_ff && i_ch7[2].count == i_ch7[2].period) |=> flag7_ff[2];
  endproperty
  a_match_set: assert property (p_match_set)
    else $error("cycle match did not set flag");

  // Complementary mode: down-count zero on channel six sets channel seven.
  property p_comp_set;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (comp_mode_ff && i_ch6[3].down && i_ch6[3].count == 16'h0000)
      |=> flag7_ff[3] && flag6_ff[3];
  endproperty
  a_comp_set: assert property (p_comp_set)
    else $error("complementary zero did not set flag");

  // Read data for channel seven never shows direction or upper bits.
  property p_stat7_zero;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (rd && i_wb.adr == `TCS_OFF_STAT7) |=> (rdat_ff[31:4] == 28'h0000000);
  endproperty
  a_stat7_zero: assert property (p_stat7_zero)
    else $error("channel seven upper bits not zero");

  // Channel six read shows direction bits and zero upper byte.
  property p_stat6_dir;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (rd && i_wb.adr == `TCS_OFF_STAT6)
      |=> rdat_ff[7:4] == {$past(i_ch6[3].down), $past(i_ch6[2].down),
                           $past(i_ch6[1].down), $past(i_ch6[0].down)}
          && rdat_ff[31:8] == 24'h000000;
  endproperty
  a_stat6_dir: assert property (p_stat6_dir)
    else $error("direction bits wrong");

  // Reserved upper bits of either status word read as zero on the bus.
  property p_upper_zero;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (rd && (i_wb.adr == `TCS_OFF_STAT6 || i_wb.adr == `TCS_OFF_STAT7))
      |=> o_wb_dat[15:8] == 8'h00;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("reserved bits nonzero");

  // Writing one never clears a flag.
  property p_write_one;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (wr && i_wb.adr == `TCS_OFF_STAT6 && i_wb.dat[1] && flag6_ff[1])
      |=> flag6_ff[1];
  endproperty
  a_write_one: assert property (p_write_one)
    else $error("write of one cleared flag");

  // Unarmed zero write does not clear.
  property p_unarmed;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (!armed6_ff[2] && flag6_ff[2]) |=> flag6_ff[2];
  endproperty
  a_unarmed: assert property (p_unarmed)
    else $error("flag cleared without prior read");

  // Ack follows a request by exactly one cycle and lasts one cycle.
  property p_ack;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      acc |=> o_wb_ack ##1 !o_wb_ack;
  endproperty
  a_ack: assert property (p_ack)
    else $error("ack timing wrong");

endmodule : tcs_cycle_status
`default_nettype wire

// ### tb/tb_tcs_cycle_status.sv
// Self-checking bench for the channel six and seven cycle status block.
`timescale 1ns/1ps
`default_nettype none
`include "tcs_map.svh"
module tb_tcs_cycle_status import tcs_pkg::*; ;
  logic             clk;             // System clock, 40 MHz.
  logic             resetn;          // Active-low reset.
  logic             ack;             // Bus acknowledge.
  logic             irq;             // Interrupt level.
  logic [31:0]      rdat;            // Bus read data.
  logic [31:0]      q;               // Last word read.
  logic [15:0]      rs;              // Random state.
  int               err_total;       // Mismatches seen.
  int               samples_checked; // Comparisons made.
  tcs_wb_req_t      wb;              // Bus request bundle.
  logic [3:0]       sel_use;         // Byte lanes of the next request.
  tcs_sub_t [3:0]   c6;              // Channel six counters.
  tcs_sub_t [3:0]   c7;              // Channel seven counters.
  tcs_cycle_status #(.NSUB(4)) tcs_cycle_status_i (.i_clk_sys(clk),
    .i_resetn(resetn), .i_wb(wb), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_ch6(c6), .i_ch7(c7), .o_irq(irq));
  // Free-running clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [15:0] nxt_rnd(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nxt_rnd
  // Expected status word: upper bits always zero.
  function automatic logic [31:0] stat_exp(input logic [3:0] d, f);
    return {24'h000000, d, f};
  endfunction : stat_exp
  function automatic logic [3:0] dirs();
    return {c6[3].down, c6[2].down, c6[1].down, c6[0].down};
  endfunction : dirs
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Fresh counts with the period kept unequal, so no flag can set by chance.
  task automatic idle(input logic [3:0] dn);
    @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      rs = nxt_rnd(rs);
      c6[k] <= '{rs | 16'h0001, ~(rs | 16'h0001), dn[k]};
      c7[k] <= '{rs | 16'h0003, ~(rs | 16'h0003), rs[k]};
    end
  endtask : idle
  // One classic cycle; the leading edge keeps cyc low at least a cycle.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    wb <= '{1'b1, 1'b1, w, a, sel_use, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    wb <= '{1'b0, 1'b0, 1'b0, a, 4'h0, d};
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask : rd
  // A single match pulse, then the write-zero clear only after a read.
  task automatic hit(input int c, input int k);
    logic [7:0] a;
    logic [3:0] m;
    logic [3:0] dv;
    a = (c != 0) ? `TCS_OFF_STAT7 : `TCS_OFF_STAT6;
    m = 4'h1 << k;
    dv = (c != 0) ? 4'h0 : dirs();
    @(posedge clk);
    if (c != 0)
      c7[k].period <= c7[k].count;
    else
      c6[k].period <= c6[k].count;
    idle(dirs());
    bus(1'b1, a, 32'h0);
    rd(a, stat_exp(dv, m), "flag kept");
    bus(1'b1, a, 32'h0000_00FF);
    rd(a, stat_exp(dv, m), "flag one");
    bus(1'b1, a, 32'h0);
    rd(a, stat_exp(dv, 4'h0), "flag clr");
  endtask : hit
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run
  // Watchdog: the sequence needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    complete_run();
  end
  initial begin
    err_total = 0;
    samples_checked = 0;
    rs = 16'hA3F7;
    resetn = 1'b0;
    wb = '0;
    sel_use = 4'hF;
    c6 = '0;
    c7 = '0;
    idle(4'h0);
    repeat (11) @(posedge clk);
    resetn <= 1'b1;
    rd(`TCS_OFF_STAT6, 32'h0, "stat6 rst");
    rd(`TCS_OFF_STAT7, 32'h0, "stat7 rst");
    rd(`TCS_OFF_MODE, 32'h0, "mode rst");
    rd(`TCS_OFF_IRQ_MSK, 32'h0, "mask rst");
    rd(8'h20, 32'h0, "unmapped");
    // Random directions; writes of ones must not touch them.
    for (int i = 0; i < 8; i++) begin
      idle(rs[3:0]);
      bus(1'b1, `TCS_OFF_STAT6, 32'h0000_00F0);
      rd(`TCS_OFF_STAT6, stat_exp(dirs(), 4'h0), "dir6");
      rd(`TCS_OFF_STAT7, 32'h0, "dir7");
    end
    for (int c = 0; c < 2; c++)
      for (int k = 0; k < 4; k++)
        hit(c, k);
    // Match held across the clearing write.
    @(posedge clk);
    c6[0].period <= c6[0].count;
    rd(`TCS_OFF_STAT6, stat_exp(dirs(), 4'h1), "held");
    bus(1'b1, `TCS_OFF_STAT6, 32'h0);
    rd(`TCS_OFF_STAT6, stat_exp(dirs(), 4'h1), "set wins");
    idle(dirs());
    // Complementary mode keys every flag on channel six zero while down.
    bus(1'b1, `TCS_OFF_MODE, 32'h1);
    @(posedge clk);
    for (int k = 0; k < 4; k++)
      c6[k] <= '{16'h0000, 16'h5A5A, 1'b1};
    rd(`TCS_OFF_STAT6, stat_exp(4'hF, 4'hF), "comp6");
    rd(`TCS_OFF_STAT7, stat_exp(4'h0, 4'hF), "comp7");
    idle(4'h0);
    bus(1'b1, `TCS_OFF_MODE, 32'h0);
    chk("irq masked", {31'h0, irq}, 32'h0);
    rd(`TCS_OFF_IRQ_ST, 32'h0000_00FF, "irq st");
    bus(1'b1, `TCS_OFF_IRQ_MSK, 32'h0000_0010);
    @(posedge clk);
    chk("irq up", {31'h0, irq}, 32'h1);
    bus(1'b1, `TCS_OFF_IRQ_ST, 32'h0000_0010);
    @(posedge clk);
    chk("irq clr", {31'h0, irq}, 32'h0);
    // Reset in mid-run must drop flags, arming, mask and interrupt status.
    @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    rd(`TCS_OFF_STAT6, stat_exp(dirs(), 4'h0), "stat6 rerun");
    rd(`TCS_OFF_STAT7, 32'h0, "stat7 rerun");
    rd(`TCS_OFF_IRQ_ST, 32'h0, "irq st rerun");
    rd(`TCS_OFF_IRQ_MSK, 32'h0, "mask rerun");
    // A write without the low byte lane must leave the mode alone.
    sel_use = 4'hE;
    bus(1'b1, `TCS_OFF_MODE, 32'h1);
    sel_use = 4'hF;
    rd(`TCS_OFF_MODE, 32'h0, "mode lane");
    complete_run();
  end
endmodule : tb_tcs_cycle_status
`default_nettype wire
